// file: rtl/usb_ep_pkg.sv
// Purpose: Shared constants and carrier types for the endpoint control block
// Assumes: APB with 32-bit data, one word per register
// Notes: Endpoint registers sit in one aligned word each from offset 0
package usb_ep_pkg;

  localparam int EP_COUNT = 16;
  localparam int EP_IDX_W = 4;
  localparam int CTRL_W = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Endpoint control field positions
  localparam int LSD_BIT = 7;
  localparam int RETRY_OFF_BIT = 6;
  localparam int CTL_BLOCK_BIT = 4;
  localparam int RX_ON_BIT = 3;
  localparam int TX_ON_BIT = 2;
  localparam int STALLED_BIT = 1;
  localparam int HSHK_BIT = 0;

  // Bits 5 and 1 never reach storage; the stall flag lives apart
  localparam logic [CTRL_W-1:0] CTRL_WRITE_MASK = 8'hdd;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

  // Register map
  localparam logic [ADDR_W-1:0] EP_CTRL_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] EP_CTRL_END = 12'h040;
  localparam logic [ADDR_W-1:0] INT_STATUS_OFF = 12'h040;
  localparam logic [ADDR_W-1:0] INT_MASK_OFF = 12'h044;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 5;

  // Interrupt event bits
  localparam int INT_W = 3;
  localparam int EVT_REJECT = 0;
  localparam int EVT_STALL = 1;
  localparam int EVT_NAK_GIVEUP = 2;
  localparam logic [INT_W-1:0] INT_RESET = 3'h0;

  typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} token_kind_t;
  typedef enum logic [1:0] {T_IDLE, T_LOOKUP, T_HOST_WAIT} tok_state_t;

  typedef struct packed {
    logic valid;
    token_kind_t kind;
    logic [EP_IDX_W-1:0] ep;
    logic host_mode;
    logic target_low_speed;
  } token_req_t;

  typedef struct packed {
    logic valid;
    logic accept;
    logic handshake;
    logic send_pre;
  } token_ans_t;

  typedef struct packed {
    logic valid;
    logic [EP_IDX_W-1:0] ep;
  } stall_evt_t;

  typedef struct packed {
    logic valid;
    logic nak;
  } host_result_t;

  typedef struct packed {
    logic [EP_COUNT-1:0][CTRL_W-1:0] entry;
    logic [CTRL_W-1:0] rd_a;
    logic [CTRL_W-1:0] rd_b;
  } mem_state_t;

  typedef struct packed {
    logic apb_wait;
    logic [DATA_W-1:0] prdata;
    logic slverr;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    logic [EP_COUNT-1:0] stalled;
    tok_state_t tstate;
    token_req_t req;
    logic [CTRL_W-1:0] snap;
    token_ans_t ans;
    logic retry;
  } ctl_state_t;

endpackage : usb_ep_pkg

// file: rtl/ep_ctrl_mem.sv
// Purpose: Sixteen endpoint control bytes, one write port, two registered read ports
// Assumes: Caller masks write data; read data appear one edge after the index
// Notes: Everything clears on reset so every endpoint starts disabled
`timescale 1ns/1ps
module ep_ctrl_mem
  import usb_ep_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [EP_IDX_W-1:0] wr_idx,
  input wire logic [CTRL_W-1:0] wr_data,
  input wire logic [EP_IDX_W-1:0] rd_a_idx,
  output logic [CTRL_W-1:0] rd_a_data,
  input wire logic [EP_IDX_W-1:0] rd_b_idx,
  output logic [CTRL_W-1:0] rd_b_data
);

  mem_state_t m_q;
  mem_state_t m_d;
  logic [EP_COUNT-1:0] hit;

  genvar gi;
  generate
    for (gi = 0; gi < EP_COUNT; gi++) begin : g_entry
      assign hit[gi] = wr_en && (wr_idx == EP_IDX_W'(gi));
    end
  endgenerate

  always_comb begin
    m_d = m_q;
    for (int i = 0; i < EP_COUNT; i++) begin
      if (hit[i]) begin
        m_d.entry[i] = wr_data;
      end
    end
    m_d.rd_a = m_q.entry[rd_a_idx];
    m_d.rd_b = m_q.entry[rd_b_idx];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  assign rd_a_data = m_q.rd_a;
  assign rd_b_data = m_q.rd_b;

endmodule : ep_ctrl_mem

// file: rtl/usb_endpoint_control.sv
// Purpose: Endpoint control registers and per-token permission logic
// Assumes: A protocol engine presents tokens and reports stalls and host results
// Notes: APB answers in the second access cycle; answer one edge after lookup
`timescale 1ns/1ps
module usb_endpoint_control
  import usb_ep_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic pready,
  output logic [DATA_W-1:0] prdata,
  output logic pslverr,
  input wire token_req_t tok_req,
  output logic tok_ready,
  output token_ans_t tok_ans,
  input wire host_result_t host_res,
  input wire stall_evt_t stall_evt,
  output logic nak_retry,
  output logic irq
);

  ctl_state_t s_q;
  ctl_state_t s_d;

  logic [CTRL_W-1:0] rd_a_data;
  logic [CTRL_W-1:0] rd_b_data;
  logic [EP_IDX_W-1:0] reg_idx;
  logic is_ctrl;
  logic is_stat;
  logic is_mask;
  logic addr_ok;
  logic apb_access;
  logic apb_done;
  logic mem_we;
  logic [CTRL_W-1:0] ctrl_rd;
  logic [INT_W-1:0] ev;
  logic [INT_W-1:0] clr;
  logic accept;
  logic both_on;
  logic host_ep0;

  assign reg_idx = paddr[IDX_MSB:IDX_LSB];
  assign is_ctrl = (paddr >= EP_CTRL_BASE) && (paddr < EP_CTRL_END) && (paddr[1:0] == 2'h0);
  assign is_stat = (paddr == INT_STATUS_OFF);
  assign is_mask = (paddr == INT_MASK_OFF);
  assign addr_ok = is_ctrl || is_stat || is_mask;
  assign apb_access = psel && penable;
  assign apb_done = apb_access && s_q.apb_wait;
  // Write data is trimmed so unimplemented bits never stick
  assign mem_we = apb_done && pwrite && is_ctrl;

  // One storage byte per endpoint number
  ep_ctrl_mem u_mem (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(mem_we),
    .wr_idx(reg_idx),
    .wr_data(pwdata[CTRL_W-1:0] & CTRL_WRITE_MASK),
    .rd_a_idx(reg_idx),
    .rd_a_data(rd_a_data),
    .rd_b_idx(tok_req.ep),
    .rd_b_data(rd_b_data)
  );

  // Read view merges the hardware stall flag into bit 1
  always_comb begin
    ctrl_rd = rd_a_data & CTRL_WRITE_MASK;
    ctrl_rd[STALLED_BIT] = s_q.stalled[reg_idx];
  end

  // Permission decision on the looked-up control byte
  always_comb begin
    both_on = rd_b_data[RX_ON_BIT] && rd_b_data[TX_ON_BIT];
    host_ep0 = s_q.req.host_mode && (s_q.req.ep == '0);
    case (s_q.req.kind)
      TOK_OUT: accept = rd_b_data[RX_ON_BIT];
      TOK_IN: accept = rd_b_data[TX_ON_BIT];
      // SETUP needs a bidirectional endpoint with control not blocked
      TOK_SETUP: accept = both_on && !rd_b_data[CTL_BLOCK_BIT];
      default: accept = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.ans.valid = 1'b0;
    s_d.retry = 1'b0;
    ev = '0;
    clr = '0;

    // First access cycle latches read data, second one completes
    if (apb_access && !s_q.apb_wait) begin
      s_d.apb_wait = 1'b1;
      s_d.slverr = !addr_ok;
      s_d.prdata = '0;
      if (is_ctrl) begin
        s_d.prdata = {{(DATA_W-CTRL_W){1'b0}}, ctrl_rd};
      end else if (is_stat) begin
        s_d.prdata = {{(DATA_W-INT_W){1'b0}}, s_q.int_status};
      end else if (is_mask) begin
        s_d.prdata = {{(DATA_W-INT_W){1'b0}}, s_q.int_mask};
      end
    end
    if (apb_done) begin
      s_d.apb_wait = 1'b0;
      if (pwrite && is_stat) begin
        clr = pwdata[INT_W-1:0];
      end
      if (pwrite && is_mask) begin
        s_d.int_mask = pwdata[INT_W-1:0];
      end
      if (pwrite && is_ctrl) begin
        s_d.stalled[reg_idx] = pwdata[STALLED_BIT];
      end
    end

    // Placed after the software write so a stall in the same cycle wins
    if (stall_evt.valid) begin
      s_d.stalled[stall_evt.ep] = 1'b1;
      ev[EVT_STALL] = 1'b1;
    end

    case (s_q.tstate)
      T_IDLE: begin
        if (tok_req.valid) begin
          s_d.req = tok_req;
          s_d.tstate = T_LOOKUP;
        end
      end
      T_LOOKUP: begin
        s_d.snap = rd_b_data;
        s_d.ans.valid = 1'b1;
        s_d.ans.accept = accept;
        s_d.ans.handshake = rd_b_data[HSHK_BIT];
        // Low-speed target behind a hub needs the PRE preamble
        s_d.ans.send_pre = host_ep0 && s_q.req.target_low_speed && !rd_b_data[LSD_BIT];
        if (!accept) begin
          ev[EVT_REJECT] = 1'b1;
        end
        if (accept && host_ep0) begin
          s_d.tstate = T_HOST_WAIT;
        end else begin
          s_d.tstate = T_IDLE;
        end
      end
      T_HOST_WAIT: begin
        if (host_res.valid) begin
          if (host_res.nak && !s_q.snap[RETRY_OFF_BIT]) begin
            // Engine reissues on this pulse; software is not involved
            s_d.retry = 1'b1;
          end else if (host_res.nak) begin
            ev[EVT_NAK_GIVEUP] = 1'b1;
            s_d.tstate = T_IDLE;
          end else begin
            s_d.tstate = T_IDLE;
          end
        end
      end
      default: begin
        s_d.tstate = T_IDLE;
      end
    endcase

    // Write-one-to-clear, new events take priority over the clear
    s_d.int_status = (s_q.int_status & ~clr) | ev;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.tstate <= T_IDLE;
      s_q.int_status <= INT_RESET;
      s_q.int_mask <= INT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready = apb_done;
  assign prdata = s_q.prdata;
  assign pslverr = apb_done && s_q.slverr;
  assign tok_ready = (s_q.tstate == T_IDLE);
  assign tok_ans = s_q.ans;
  assign nak_retry = s_q.retry;
  assign irq = |(s_q.int_status & s_q.int_mask);

  property p_rx_gate;
    @(posedge clock) disable iff (!rst_n)
    (s_q.tstate == T_LOOKUP && s_q.req.kind == TOK_OUT)
      |=> (tok_ans.valid && tok_ans.accept == $past(rd_b_data[RX_ON_BIT]));
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("OUT permission wrong");

  property p_tx_gate;
    @(posedge clock) disable iff (!rst_n)
    (s_q.tstate == T_LOOKUP && s_q.req.kind == TOK_IN)
      |=> (tok_ans.valid && tok_ans.accept == $past(rd_b_data[TX_ON_BIT]));
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("IN permission wrong");

  property p_setup_block;
    @(posedge clock) disable iff (!rst_n)
    (s_q.tstate == T_LOOKUP && s_q.req.kind == TOK_SETUP && both_on
      && rd_b_data[CTL_BLOCK_BIT]) |=> (tok_ans.valid && !tok_ans.accept);
  endproperty
  a_setup_block: assert property (p_setup_block) else $error("SETUP not blocked");

  property p_setup_ok;
    @(posedge clock) disable iff (!rst_n)
    (s_q.tstate == T_LOOKUP && s_q.req.kind == TOK_SETUP && both_on
      && !rd_b_data[CTL_BLOCK_BIT]) |=> (tok_ans.valid && tok_ans.accept);
  endproperty
  a_setup_ok: assert property (p_setup_ok) else $error("SETUP wrongly refused");

  property p_handshake;
    @(posedge clock) disable iff (!rst_n)
    (s_q.tstate == T_LOOKUP) |=> (tok_ans.handshake == $past(rd_b_data[HSHK_BIT]));
  endproperty
  a_handshake: assert property (p_handshake) else $error("Handshake flag wrong");

  property p_pre;
    @(posedge clock) disable iff (!rst_n)
    (s_q.tstate == T_LOOKUP && host_ep0 && s_q.req.target_low_speed)
      |=> (tok_ans.send_pre == !$past(rd_b_data[LSD_BIT]));
  endproperty
  a_pre: assert property (p_pre) else $error("PRE choice wrong");

  property p_giveup;
    @(posedge clock) disable iff (!rst_n)
    (s_q.tstate == T_HOST_WAIT && host_res.valid && host_res.nak && s_q.snap[RETRY_OFF_BIT])
      |=> (!nak_retry && s_q.int_status[EVT_NAK_GIVEUP] && tok_ready);
  endproperty
  a_giveup: assert property (p_giveup) else $error("NAK retried while disabled");

  property p_retry;
    @(posedge clock) disable iff (!rst_n)
    (s_q.tstate == T_HOST_WAIT && host_res.valid && host_res.nak && !s_q.snap[RETRY_OFF_BIT])
      |=> (nak_retry && s_q.tstate == T_HOST_WAIT);
  endproperty
  a_retry: assert property (p_retry) else $error("NAK not retried");

  property p_stall_set;
    @(posedge clock) disable iff (!rst_n)
    stall_evt.valid |=> s_q.stalled[$past(stall_evt.ep)];
  endproperty
  a_stall_set: assert property (p_stall_set) else $error("Stall flag not set");

  property p_read_zero;
    @(posedge clock) disable iff (!rst_n)
    (pready && !pwrite && is_ctrl) |-> (prdata[DATA_W-1:CTRL_W] == '0 && !prdata[5]);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("Unused bits read nonzero");

  property p_ep_mapped;
    @(posedge clock) disable iff (!rst_n)
    (pready && is_ctrl) |-> !pslverr;
  endproperty
  a_ep_mapped: assert property (p_ep_mapped) else $error("Endpoint register unmapped");

  property p_reset_clear;
    @(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> (s_q.stalled == '0 && tok_ready);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("State not cleared");

  property p_setup_ignored;
    @(posedge clock) disable iff (!rst_n)
    (s_q.tstate == T_LOOKUP && s_q.req.kind == TOK_SETUP && !both_on)
      |=> (tok_ans.valid && !tok_ans.accept);
  endproperty
  a_setup_ignored: assert property (p_setup_ignored) else $error("SETUP taken one-way");

  property p_pre_host_only;
    @(posedge clock) disable iff (!rst_n)
    (s_q.tstate == T_LOOKUP && !host_ep0) |=> !tok_ans.send_pre;
  endproperty
  a_pre_host_only: assert property (p_pre_host_only) else $error("PRE outside host ep0");

  property p_answer_time;
    @(posedge clock) disable iff (!rst_n)
    (tok_req.valid && tok_ready) |-> ##2 tok_ans.valid;
  endproperty
  a_answer_time: assert property (p_answer_time) else $error("Token answer late");

  property p_reject_flag;
    @(posedge clock) disable iff (!rst_n)
    (s_q.tstate == T_LOOKUP && !accept) |=> s_q.int_status[EVT_REJECT];
  endproperty
  a_reject_flag: assert property (p_reject_flag) else $error("Reject not flagged");

  property p_retry_ep0;
    @(posedge clock) disable iff (!rst_n)
    nak_retry |-> (host_ep0 && s_q.tstate == T_HOST_WAIT);
  endproperty
  a_retry_ep0: assert property (p_retry_ep0) else $error("Retry outside host ep0");

  property p_no_retry_off;
    @(posedge clock) disable iff (!rst_n)
    (s_q.tstate == T_HOST_WAIT && s_q.snap[RETRY_OFF_BIT]) |=> !nak_retry;
  endproperty
  a_no_retry_off: assert property (p_no_retry_off) else $error("Retry while disabled");

  property p_stall_status;
    @(posedge clock) disable iff (!rst_n)
    stall_evt.valid |=> s_q.int_status[EVT_STALL];
  endproperty
  a_stall_status: assert property (p_stall_status) else $error("Stall not flagged");

  property p_stall_read;
    @(posedge clock) disable iff (!rst_n)
    (pready && !pwrite && is_ctrl) |-> (prdata[STALLED_BIT] == $past(s_q.stalled[reg_idx]));
  endproperty
  a_stall_read: assert property (p_stall_read) else $error("Stall bit misread");

  property p_unused_store;
    @(posedge clock) disable iff (!rst_n)
    (!rd_a_data[5] && !rd_b_data[5]);
  endproperty
  a_unused_store: assert property (p_unused_store) else $error("Bit 5 stored");

  c_setup_ok: cover property (@(posedge clock) disable iff (!rst_n)
    tok_ans.valid && tok_ans.accept && s_q.req.kind == TOK_SETUP);
  c_in_reject: cover property (@(posedge clock) disable iff (!rst_n)
    tok_ans.valid && !tok_ans.accept && s_q.req.kind == TOK_IN);
  c_retry: cover property (@(posedge clock) disable iff (!rst_n) nak_retry);
  c_irq: cover property (@(posedge clock) disable iff (!rst_n) $rose(irq));
  c_giveup: cover property (@(posedge clock) disable iff (!rst_n)
    $rose(s_q.int_status[EVT_NAK_GIVEUP]));

endmodule : usb_endpoint_control

// file: tb/usb_engine_model.sv
// Purpose: Protocol-engine stand-in issuing tokens, host results and stalls
// Assumes: A token is taken on an edge where valid and tok_ready are both high
// Notes: Always names a low-speed target so the PRE choice shows on every host token to endpoint 0
`timescale 1ns/1ps
module usb_engine_model
  import usb_ep_pkg::*;
(
  input wire logic clock,
  input wire logic tok_ready,
  input wire token_ans_t tok_ans,
  output token_req_t tok_req,
  output host_result_t host_res,
  output stall_evt_t stall_evt
);
  initial begin
    tok_req = '0;
    host_res = '0;
    stall_evt = '0;
  end

  task automatic token(input token_kind_t k, input logic [EP_IDX_W-1:0] ep, input logic host,
                       output token_ans_t a);
    int n;
    tok_req <= '{valid: 1'b1, kind: k, ep: ep, host_mode: host, target_low_speed: 1'b1};
    do @(posedge clock); while (tok_ready !== 1'b1);
    // Released ep, host and speed fields flip so a stale value cannot pass
    tok_req <= '{valid: 1'b0, kind: TOK_SETUP, ep: ~ep, host_mode: ~host, target_low_speed: 1'b0};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (tok_ans.valid !== 1'b1 && n < 8);
    a = tok_ans;
  endtask : token

  task automatic host_result(input logic nak);
    host_res <= '{valid: 1'b1, nak: nak};
    @(posedge clock);
    host_res <= '0;
    @(posedge clock);
  endtask : host_result

  task automatic stall(input logic [EP_IDX_W-1:0] ep);
    stall_evt <= '{valid: 1'b1, ep: ep};
    @(posedge clock);
    stall_evt <= '0;
    @(posedge clock);
  endtask : stall
endmodule : usb_engine_model

// file: tb/usb_endpoint_control_tb_top.sv
// Purpose: Self-checking bench for the endpoint control block
// Assumes: APB master tasks and the engine model drive every input except clock and rst_n, which the bench drives directly
// Notes: Each APB transfer ends with one idle cycle to keep drivers race-free
`timescale 1ns/1ps
module usb_endpoint_control_tb_top
  import usb_ep_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic pready, pslverr, tok_ready, nak_retry, irq;
  logic [DATA_W-1:0] prdata;
  token_req_t tok_req;
  token_ans_t tok_ans;
  host_result_t host_res;
  stall_evt_t stall_evt;
  int bad_count = 0;
  int check_count = 0;
  int retries = 0;

  always #50 clock = ~clock;
  always @(posedge clock) if (nak_retry === 1'b1) retries <= retries + 1;

  usb_endpoint_control usb_endpoint_control_inst (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .tok_req(tok_req), .tok_ready(tok_ready),
    .tok_ans(tok_ans), .host_res(host_res), .stall_evt(stall_evt), .nak_retry(nak_retry),
    .irq(irq));

  usb_engine_model usb_engine_model_inst (.clock(clock), .tok_ready(tok_ready),
    .tok_ans(tok_ans), .tok_req(tok_req), .host_res(host_res), .stall_evt(stall_evt));

  task automatic chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x,
                     input logic xe);
    logic [DATA_W-1:0] r;
    logic e;
    apb(1'b0, a, '0, r, e);
    chk(n, r, x);
    chk({n, "_err"}, DATA_W'(e), DATA_W'(xe));
  endtask : rdc

  task automatic t_reset();
    for (int i = 0; i < EP_COUNT; i++) rdc("ep_reset", ADDR_W'(4 * i), '0, 1'b0);
    rdc("unmapped", 12'h048, '0, 1'b1);
    rdc("misaligned", 12'h002, '0, 1'b1);
  endtask : t_reset

  task automatic t_fields();
    for (int i = 0; i < EP_COUNT; i++) begin
      wr(ADDR_W'(4 * i), 32'hffff_fffd);
      rdc("ep_fields", ADDR_W'(4 * i), 32'h0000_00dd, 1'b0);
      wr(ADDR_W'(4 * i), 32'h0000_0000);
    end
  endtask : t_fields

  task automatic t_perm();
    logic [7:0] cfg [6] = '{8'h00, 8'h04, 8'h18, 8'h0c, 8'h1c, 8'h1d};
    token_ans_t a;
    logic ok;
    for (int c = 0; c < 6; c++) begin
      wr(12'h014, {24'h0, cfg[c]});
      for (int k = 0; k < 3; k++) begin
        usb_engine_model_inst.token(token_kind_t'(k), 4'h5, c[0], a);
        ok = (k == 0) ? cfg[c][3] : (k == 1) ? cfg[c][2] : (cfg[c][3] & cfg[c][2] & ~cfg[c][4]);
        chk("token", DATA_W'(a), DATA_W'({1'b1, ok, cfg[c][0], 1'b0}));
      end
    end
    rdc("reject_status", INT_STATUS_OFF, 32'h1, 1'b0);
    wr(INT_STATUS_OFF, 32'h1);
  endtask : t_perm

  task automatic t_host();
    token_ans_t a;
    wr(EP_CTRL_BASE, 32'h0d);
    usb_engine_model_inst.token(TOK_IN, 4'h0, 1'b1, a);
    chk("pre_hub", DATA_W'(a), 32'hf);
    usb_engine_model_inst.host_result(1'b1);
    repeat (2) @(posedge clock);
    chk("retry", DATA_W'(retries), 32'h1);
    usb_engine_model_inst.host_result(1'b0);
    wr(EP_CTRL_BASE, 32'hcd);
    usb_engine_model_inst.token(TOK_IN, 4'h0, 1'b1, a);
    chk("pre_direct", DATA_W'(a), 32'he);
    usb_engine_model_inst.host_result(1'b1);
    repeat (2) @(posedge clock);
    chk("no_retry", DATA_W'(retries), 32'h1);
    rdc("giveup_status", INT_STATUS_OFF, 32'h4, 1'b0);
    wr(INT_STATUS_OFF, 32'h4);
    wr(EP_CTRL_BASE, 32'h0);
  endtask : t_host

  task automatic t_irq();
    usb_engine_model_inst.stall(4'h3);
    rdc("stall_flag", 12'h00c, 32'h2, 1'b0);
    rdc("other_ep", 12'h010, 32'h0, 1'b0);
    wr(12'h00c, 32'h0);
    rdc("stall_clear", 12'h00c, 32'h0, 1'b0);
    chk("irq_masked", DATA_W'(irq), 32'h0);
    wr(INT_MASK_OFF, 32'h2);
    chk("irq_on", DATA_W'(irq), 32'h1);
    wr(INT_STATUS_OFF, 32'h2);
    chk("irq_clear", DATA_W'(irq), 32'h0);
    rdc("status_clear", INT_STATUS_OFF, 32'h0, 1'b0);
  endtask : t_irq

  // Reset in mid-run must wipe config, stall flags, status and mask
  task automatic t_mid_reset();
    wr(12'h018, 32'h0000_001d);
    usb_engine_model_inst.stall(4'h6);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("rst_irq", DATA_W'(irq), 32'h0);
    chk("rst_ready", DATA_W'(tok_ready), 32'h1);
    rdc("rst_ep6", 12'h018, '0, 1'b0);
    rdc("rst_status", INT_STATUS_OFF, '0, 1'b0);
    rdc("rst_mask", INT_MASK_OFF, '0, 1'b0);
  endtask : t_mid_reset

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_fields();
    t_perm();
    t_host();
    t_irq();
    t_mid_reset();
    summarize();
  end

  // Run needs a few hundred cycles; this margin only catches hangs
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    summarize();
  end
endmodule : usb_endpoint_control_tb_top
